//--- hw/prw_pkg.sv
package prw_pkg;

    // oscillator rate and the watchdog timebase
    localparam int unsigned CLK_MHZ       = 50;
    localparam int unsigned TICK_DIV      = 100;
    localparam logic [6:0]  TICK_LAST     = 7'(TICK_DIV - 1);

    // window and reset lengths in watchdog cycles
    localparam int unsigned HOLD_TICKS    = 64;
    localparam int unsigned CLOSED_TICKS  = 32;
    localparam int unsigned OPEN_TICKS    = 32;
    localparam logic [5:0]  HOLD_LAST     = 6'(HOLD_TICKS - 1);
    localparam logic [5:0]  CLOSED_LAST   = 6'(CLOSED_TICKS - 1);
    localparam logic [5:0]  WIN_LAST      = 6'(CLOSED_TICKS + OPEN_TICKS - 1);

    // supply glitch filter: least time a dip must last, rounded up to cycles
    localparam int unsigned GLITCH_FILTER_TIME_NS = 1000;
    localparam int unsigned GLITCH_CYCLES =
        (GLITCH_FILTER_TIME_NS * CLK_MHZ + 999) / 1000;

    // sample pattern of a valid trigger before the final low sample
    localparam logic [2:0]  TRIG_PATTERN  = 3'h6;

    // values after reset
    localparam logic [6:0]  TICK_RST      = 7'h00;
    localparam logic [5:0]  WIN_RST       = 6'h00;
    localparam logic [2:0]  SMP_RST       = 3'h0;
    localparam logic [7:0]  FLT_RST       = 8'h00;

    // window sequencer states
    typedef enum logic [1:0] {
        ST_HOLD    = 2'b00,
        ST_CLOSED  = 2'b01,
        ST_OPEN    = 2'b10,
        ST_PRETRIG = 2'b11
    } prw_state_e;

    // open-drain pin: level driven and its enable
    typedef struct packed {
        logic drv;
        logic oe;
    } prw_od_pin_s;

endpackage

//--- hw/prw_por_watchdog.sv
`timescale 1ns/1ps
// What this block does
// - watchdog cycle is one hundred oscillator periods
// - sustained low supply drives reset output low
// - supply dips shorter than filter are ignored
// - after supply good, hold reset 64 cycles
// - reset release starts 32-cycle closed window
// - trigger inside closed window is a pretrigger
// - open window ends on trigger, max 32
// - sample once per cycle; high,high,low,low valid
// - valid trigger or power event restarts closed window
// - fault resets at 64 after window start, 64 long
// - only last low sample in open is correct
// - first valid trigger raises system enable
// - system enable drops at once on faults
// - reset output is open-drain, idles high
module prw_por_watchdog #(
    parameter int unsigned GLITCH_CYCLES = prw_pkg::GLITCH_CYCLES
) (
    input  wire logic           clk,
    input  wire logic           sys_rst,
    input  wire logic           vcc_below_threshold,
    input  wire logic           watchdog_trigger_input,
    output prw_pkg::prw_od_pin_s reset_output,
    output logic                system_enable
);

    localparam logic [7:0] FLT_LAST = 8'(GLITCH_CYCLES - 1);

    logic                 vcc_meta_reg;
    logic                 vcc_sync_reg;
    logic                 trig_meta_reg;
    logic                 trig_sync_reg;
    logic [6:0]           tick_cnt_reg;
    logic [6:0]           tick_cnt_next;
    logic [7:0]           flt_cnt_reg;
    logic [7:0]           flt_cnt_next;
    logic                 vcc_fail_reg;
    logic                 vcc_fail_next;
    logic [2:0]           smp_reg;
    logic [2:0]           smp_next;
    logic [5:0]           win_cnt_reg;
    logic [5:0]           win_cnt_next;
    prw_pkg::prw_state_e  state_reg;
    prw_pkg::prw_state_e  state_next;
    prw_pkg::prw_od_pin_s rst_pin_reg;
    prw_pkg::prw_od_pin_s rst_pin_next;
    logic                 sen_reg;
    logic                 sen_next;
    wire                  tick;
    wire                  trig_valid;
    wire                  flt_full;

    // two-stage synchronisers
    // both pins are asynchronous to the oscillator; only the second stage is read
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            vcc_meta_reg  <= 1'b0;
            vcc_sync_reg  <= 1'b0;
            trig_meta_reg <= 1'b0;
            trig_sync_reg <= 1'b0;
        end else begin
            vcc_meta_reg  <= vcc_below_threshold;
            vcc_sync_reg  <= vcc_meta_reg;
            trig_meta_reg <= watchdog_trigger_input;
            trig_sync_reg <= trig_meta_reg;
        end
    end

    // timebase divider
    // free running so the tick phase never depends on the window sequencing
    assign tick          = (tick_cnt_reg == prw_pkg::TICK_LAST);
    assign tick_cnt_next = tick ? prw_pkg::TICK_RST : 7'(tick_cnt_reg + 7'h01);

    // reaction-time filter
    // a dip must stay low for the full count before it counts as a power-down
    assign flt_full      = (flt_cnt_reg == FLT_LAST);
    assign flt_cnt_next  = !vcc_sync_reg ? prw_pkg::FLT_RST :
                           flt_full      ? flt_cnt_reg : 8'(flt_cnt_reg + 8'h01);
    assign vcc_fail_next = vcc_sync_reg & (vcc_fail_reg | flt_full);

    // trigger sampling once per watchdog cycle
    // a valid trigger is the fourth sample low after the pattern high,high,low
    assign smp_next   = (state_reg == prw_pkg::ST_HOLD) ? prw_pkg::SMP_RST :
                        tick ? {smp_reg[1:0], trig_sync_reg} : smp_reg;
    assign trig_valid = tick & (smp_reg == prw_pkg::TRIG_PATTERN) & ~trig_sync_reg;

    // window sequencer, reset pin and system enable
    always_comb begin
        state_next   = state_reg;
        win_cnt_next = win_cnt_reg;
        rst_pin_next = rst_pin_reg;
        sen_next     = sen_reg;
        rst_pin_next.drv = 1'b0;
        if (vcc_fail_reg) begin
            // supply low holds reset and restarts sequencing
            state_next       = prw_pkg::ST_HOLD;
            win_cnt_next     = prw_pkg::WIN_RST;
            rst_pin_next.oe  = 1'b1;
            sen_next         = 1'b0;
        end else if (tick) begin
            case (state_reg)
                prw_pkg::ST_HOLD: begin
                    // reset hold count, also used after a fault
                    if (win_cnt_reg == prw_pkg::HOLD_LAST) begin
                        state_next      = prw_pkg::ST_CLOSED;
                        win_cnt_next    = prw_pkg::WIN_RST;
                        rst_pin_next.oe = 1'b0;
                    end else begin
                        win_cnt_next = 6'(win_cnt_reg + 6'h01);
                    end
                end
                prw_pkg::ST_CLOSED: begin
                    win_cnt_next = 6'(win_cnt_reg + 6'h01);
                    if (trig_valid) begin
                        state_next = prw_pkg::ST_PRETRIG;
                        sen_next   = 1'b0;
                    end else if (win_cnt_reg == prw_pkg::CLOSED_LAST) begin
                        // the next sample already falls in the open window
                        state_next = prw_pkg::ST_OPEN;
                    end
                end
                prw_pkg::ST_OPEN: begin
                    if (trig_valid) begin
                        state_next   = prw_pkg::ST_CLOSED;
                        win_cnt_next = prw_pkg::WIN_RST;
                        sen_next     = 1'b1;
                    end else if (win_cnt_reg == prw_pkg::WIN_LAST) begin
                        state_next      = prw_pkg::ST_HOLD;
                        win_cnt_next    = prw_pkg::WIN_RST;
                        rst_pin_next.oe = 1'b1;
                        sen_next        = 1'b0;
                    end else begin
                        win_cnt_next = 6'(win_cnt_reg + 6'h01);
                    end
                end
                prw_pkg::ST_PRETRIG: begin
                    // reset waits for 64 cycles after window start
                    if (win_cnt_reg == prw_pkg::WIN_LAST) begin
                        state_next      = prw_pkg::ST_HOLD;
                        win_cnt_next    = prw_pkg::WIN_RST;
                        rst_pin_next.oe = 1'b1;
                    end else begin
                        win_cnt_next = 6'(win_cnt_reg + 6'h01);
                    end
                end
                default: begin
                    state_next      = prw_pkg::ST_HOLD;
                    win_cnt_next    = prw_pkg::WIN_RST;
                    rst_pin_next.oe = 1'b1;
                    sen_next        = 1'b0;
                end
            endcase
        end
    end

    // state registers; reset starts in the power-up hold with the pin pulled low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tick_cnt_reg <= prw_pkg::TICK_RST;
            flt_cnt_reg  <= prw_pkg::FLT_RST;
            vcc_fail_reg <= 1'b0;
            smp_reg      <= prw_pkg::SMP_RST;
            win_cnt_reg  <= prw_pkg::WIN_RST;
            state_reg    <= prw_pkg::ST_HOLD;
            rst_pin_reg  <= '{drv: 1'b0, oe: 1'b1};
            sen_reg      <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            flt_cnt_reg  <= flt_cnt_next;
            vcc_fail_reg <= vcc_fail_next;
            smp_reg      <= smp_next;
            win_cnt_reg  <= win_cnt_next;
            state_reg    <= state_next;
            rst_pin_reg  <= rst_pin_next;
            sen_reg      <= sen_next;
        end
    end

    // open-drain pin, only ever pulled low; the pull-up sits outside
    assign reset_output  = rst_pin_reg;
    assign system_enable = sen_reg;

    // checks on the sequencer
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_tick_spacing;
        tick |=> !tick [*8];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing)
        else $error("tick spacing too short");

    property p_supply_reset;
        vcc_fail_reg |=> rst_pin_reg.oe && !sen_reg && state_reg == prw_pkg::ST_HOLD;
    endproperty
    a_supply_reset: assert property (p_supply_reset)
        else $error("supply low without reset");

    property p_glitch_filter;
        $rose(vcc_fail_reg) |-> $past(vcc_sync_reg, 1) && $past(vcc_sync_reg, 2)
                                && $past(vcc_sync_reg, 3);
    endproperty
    a_glitch_filter: assert property (p_glitch_filter)
        else $error("short dip caused fail");

    property p_hold_release;
        $fell(rst_pin_reg.oe) |-> $past(win_cnt_reg) == prw_pkg::HOLD_LAST && $past(tick);
    endproperty
    a_hold_release: assert property (p_hold_release)
        else $error("reset released early");

    property p_closed_start;
        $fell(rst_pin_reg.oe) |-> state_reg == prw_pkg::ST_CLOSED && win_cnt_reg == 6'h00;
    endproperty
    a_closed_start: assert property (p_closed_start)
        else $error("no closed window on release");

    property p_pretrigger;
        state_reg == prw_pkg::ST_CLOSED && trig_valid && !vcc_fail_reg
            |=> state_reg == prw_pkg::ST_PRETRIG && !sen_reg;
    endproperty
    a_pretrigger: assert property (p_pretrigger)
        else $error("pretrigger missed");

    property p_open_timeout;
        state_reg == prw_pkg::ST_OPEN && tick && !trig_valid && !vcc_fail_reg
            && win_cnt_reg == prw_pkg::WIN_LAST |=> rst_pin_reg.oe && !sen_reg;
    endproperty
    a_open_timeout: assert property (p_open_timeout)
        else $error("missing trigger not reset");

    property p_fault_timing;
        $rose(rst_pin_reg.oe) && !$past(vcc_fail_reg)
            |-> $past(win_cnt_reg) == prw_pkg::WIN_LAST && win_cnt_reg == 6'h00;
    endproperty
    a_fault_timing: assert property (p_fault_timing)
        else $error("fault reset at wrong time");

    property p_enable_rise;
        $rose(sen_reg) |-> $past(trig_valid) && $past(state_reg) == prw_pkg::ST_OPEN
                           && state_reg == prw_pkg::ST_CLOSED && !rst_pin_reg.oe;
    endproperty
    a_enable_rise: assert property (p_enable_rise)
        else $error("enable rose without trigger");

    property p_pin_low_only;
        !reset_output.drv;
    endproperty
    a_pin_low_only: assert property (p_pin_low_only)
        else $error("reset pin driven high");

    // sampling, window phases and enable; the tick spacing is fixed at one hundred clocks
    property p_tick_period;
        tick |-> ##100 tick;
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("tick period not one hundred clocks");

    property p_hold_pin;
        state_reg == prw_pkg::ST_HOLD |-> rst_pin_reg.oe && !sen_reg;
    endproperty
    a_hold_pin: assert property (p_hold_pin)
        else $error("reset released during hold");

    property p_closed_phase;
        state_reg == prw_pkg::ST_CLOSED |-> win_cnt_reg <= prw_pkg::CLOSED_LAST;
    endproperty
    a_closed_phase: assert property (p_closed_phase)
        else $error("closed window too long");

    property p_open_phase;
        state_reg == prw_pkg::ST_OPEN |-> win_cnt_reg > prw_pkg::CLOSED_LAST && !rst_pin_reg.oe;
    endproperty
    a_open_phase: assert property (p_open_phase)
        else $error("open window out of place");

    // the three earlier samples sit one, two and three ticks back
    property p_trig_samples;
        trig_valid |-> !trig_sync_reg && !$past(trig_sync_reg, 100)
                       && $past(trig_sync_reg, 200) && $past(trig_sync_reg, 300);
    endproperty
    a_trig_samples: assert property (p_trig_samples)
        else $error("trigger accepted on wrong samples");

    property p_open_restart;
        state_reg == prw_pkg::ST_OPEN && trig_valid && !vcc_fail_reg
            |=> state_reg == prw_pkg::ST_CLOSED && win_cnt_reg == 6'h00 && sen_reg;
    endproperty
    a_open_restart: assert property (p_open_restart)
        else $error("good trigger did not restart window");

    property p_pretrig_wait;
        state_reg == prw_pkg::ST_PRETRIG |-> !sen_reg && !rst_pin_reg.oe;
    endproperty
    a_pretrig_wait: assert property (p_pretrig_wait)
        else $error("pretrigger wait state wrong");

    property p_enable_drop;
        $fell(sen_reg) |-> rst_pin_reg.oe || state_reg == prw_pkg::ST_PRETRIG;
    endproperty
    a_enable_drop: assert property (p_enable_drop)
        else $error("enable dropped without fault");

    property p_sync_chain;
        vcc_sync_reg == $past(vcc_meta_reg) && trig_sync_reg == $past(trig_meta_reg);
    endproperty
    a_sync_chain: assert property (p_sync_chain)
        else $error("synchroniser stage skipped");

endmodule // prw_por_watchdog

//--- bench/prw_mcu_model.sv
`timescale 1ns/1ps
// controller side: one high-then-low trigger pulse per request
module prw_mcu_model (
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic [15:0] hi_len,
    output logic             trigger
);
    logic [15:0] left_reg = 16'h0000;

    // pulse high then low
    // a pulse ends low and stays low, so every pulse is followed by low samples
    always_ff @(posedge clk) begin
        if (go) begin
            left_reg <= hi_len;
        end else if (left_reg != 16'h0000) begin
            left_reg <= left_reg - 16'h0001;
        end
    end

    assign trigger = (left_reg != 16'h0000);
endmodule // prw_mcu_model

//--- bench/prw_por_watchdog_test.sv
`timescale 1ns/1ps
module prw_por_watchdog_test;
    localparam int unsigned GLITCH = 4;
    logic                 clk     = 1'b0;
    logic                 sys_rst = 1'b1;
    logic                 vcc_low = 1'b0;
    logic                 go      = 1'b0;
    logic [15:0]          hi_len  = 16'h00C8;
    logic                 trig;
    prw_pkg::prw_od_pin_s rst_o;
    logic                 sys_en;
    int                   cyc = 0;
    int                   n_mismatch = 0;
    int                   checked = 0;
    // pull-up on the pin: released means high
    wire                  rst_pin = ~rst_o.oe;

    always #10 clk = ~clk;
    // cycle count since reset release, used to place ticks and windows
    always @(posedge clk) cyc <= sys_rst ? 0 : cyc + 1;

    prw_por_watchdog #(.GLITCH_CYCLES(GLITCH)) u_prw_por_watchdog (
        .clk                    (clk),
        .sys_rst                (sys_rst),
        .vcc_below_threshold    (vcc_low),
        .watchdog_trigger_input (trig),
        .reset_output           (rst_o),
        .system_enable          (sys_en)
    );
    prw_mcu_model u_prw_mcu_model (.clk(clk), .go(go), .hi_len(hi_len), .trigger(trig));

    // sample at the falling edge so outputs have settled
    task automatic at(input int c);
        int guard = 0;
        while (cyc < c && guard < 20000) begin
            @(posedge clk);
            guard++;
        end
        if (cyc < c) begin
            n_mismatch++;
            final_report();
        end else begin
            @(negedge clk);
        end
    endtask
    task automatic chk(input logic e, input logic g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic pulse(input int c, input logic [15:0] len);
        at(c);
        @(posedge clk);
        go     <= 1'b1;
        hi_len <= len;
        @(posedge clk);
        go <= 1'b0;
    endtask
    task automatic final_report;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // samples land mid-tick: two high at counts 39,40, two low at 41,42
    task automatic t_service(input int w, input logic en_before);
        pulse(w + 3950, 16'h00C8);
        at(w + 4250);
        chk(en_before, sys_en);
        at(w + 4350);
        chk(1'b1, sys_en);
        chk(1'b1, rst_pin);
    endtask
    // pretrigger or missing trigger, reset 64 ticks after window start
    task automatic t_fault(input int w, input logic pre);
        if (pre) begin
            pulse(w + 450, 16'h00C8);
            at(w + 900);
            chk(1'b0, sys_en);
        end
        at(w + 6350);
        chk(1'b1, rst_pin);
        at(w + 6450);
        chk(1'b0, rst_pin);
        chk(1'b0, sys_en);
        at(w + 12750);
        chk(1'b0, rst_pin);
        at(w + 12850);
        chk(1'b1, rst_pin);
    endtask
    task automatic t_supply(input int w);
        at(w + 1000);
        @(posedge clk);
        vcc_low <= 1'b1;
        repeat (GLITCH - 1) @(posedge clk);
        vcc_low <= 1'b0;
        at(w + 1100);
        chk(1'b1, rst_pin);
        t_service(w, 1'b0);
        at(w + 5000);
        @(posedge clk);
        vcc_low <= 1'b1;
        at(w + 5012);
        chk(1'b0, rst_pin);
        chk(1'b0, sys_en);
        at(w + 5020);
        @(posedge clk);
        vcc_low <= 1'b0;
        at(w + 5020 + 6250);
        chk(1'b0, rst_pin);
        at(w + 5020 + 6550);
        chk(1'b1, rst_pin);
    endtask

    // power-up hold: pin pulled low for 64 ticks, never driven high
    task automatic t_power_up;
        at(6350);
        chk(1'b0, rst_pin);
        chk(1'b0, sys_en);
        chk(1'b0, rst_o.drv);
        at(6450);
        chk(1'b1, rst_pin);
    endtask
    // a one-sample pulse must be ignored, else the later good trigger lands in a pretrigger
    // good trigger: highs at ticks 29,30, lows at 31,32 so only the last low is open
    task automatic t_boundary(input int w);
        pulse(w + 450, 16'h0064);
        pulse(w + 2950, 16'h00C8);
        at(w + 3250);
        chk(1'b0, sys_en);
        at(w + 3350);
        chk(1'b1, sys_en);
        chk(1'b1, rst_pin);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        t_power_up();
        t_service(6400, 1'b0);
        t_service(10700, 1'b1);
        t_fault(15000, 1'b1);
        t_boundary(27800);
        t_service(31100, 1'b1);
        t_fault(35400, 1'b0);
        t_supply(48200);
        final_report();
    end
    // hang guard: well past the longest planned sequence
    initial begin
        #2000000;
        n_mismatch++;
        final_report();
    end
endmodule // prw_por_watchdog_test
